// ==== rtl/dhg_consts.svh ====
// Purpose: addresses, field positions, reset values and timing counts of the dma glue
// Assumes: 50 MHz system clock, 16-bit local i/o data
// Notes: times are in ns; cycle counts derive from them and the clock period
`ifndef DHG_CONSTS_SVH
`define DHG_CONSTS_SVH

// ==========
// local i/o addresses
`define DHG_ADDR_DATA 32'h180E_0002
`define DHG_ADDR_PTR 32'h180E_0006
`define DHG_ADDR_IACK 32'h180E_000A
`define DHG_ADDR_SYS_CFG 32'h1800_0002
`define DHG_ADDR_EXP_CTL 32'h1800_0012

// ==========
// field positions
`define DHG_SYS_RO_MSB 7
`define DHG_SYS_SW_TERM 10
`define DHG_SYS_DONE_EN 12
`define DHG_SYS_SLOW_RD 13
`define DHG_EXP_FLOW_DIR 15
`define DHG_EXP_FLOW_SEL 14
`define DHG_EXP_ACK_EN_N 13
`define DHG_EXP_REQ_EN 12

// ==========
// reset values
`define DHG_SYS_CFG_RST 16'h0000
`define DHG_EXP_CTL_RST 16'h0000

// ==========
// timing
`define DHG_CLK_NS 20
`define DHG_SETUP_NS 20
`define DHG_STROBE_NS 120
`define DHG_SLOW_EXTRA_NS 400
`define DHG_RECOVER_NS 60
`define DHG_IACK_NS 100
`define DHG_SETUP_CYC ((`DHG_SETUP_NS + `DHG_CLK_NS - 1) / `DHG_CLK_NS)
`define DHG_STROBE_CYC ((`DHG_STROBE_NS + `DHG_CLK_NS - 1) / `DHG_CLK_NS)
`define DHG_SLOW_EXTRA_CYC ((`DHG_SLOW_EXTRA_NS + `DHG_CLK_NS - 1) / `DHG_CLK_NS)
`define DHG_RECOVER_CYC ((`DHG_RECOVER_NS + `DHG_CLK_NS - 1) / `DHG_CLK_NS)
`define DHG_IACK_CYC ((`DHG_IACK_NS + `DHG_CLK_NS - 1) / `DHG_CLK_NS)

`endif

// ==== rtl/dhg_pkg.sv ====
// Purpose: types shared by the dma glue modules
// Assumes: field positions as in dhg_consts.svh
// Notes: holds types only
package dhg_pkg;

    // ==========
    // controller access sequencer states
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_SETUP, SEQ_STROBE, SEQ_RECOVER} dhg_seq_state_t;

    // ==========
    // system configuration register layout
    typedef struct packed {
        logic parity_en;
        logic force_bad_par;
        logic slow_register_read_enable;
        logic expansion_done_enable;
        logic exp_bus_reset_n;
        logic software_terminate;
        logic scsi_dir;
        logic scsi_reset;
        logic [7:0] status;
    } dhg_sys_cfg_t;

    // expansion-bus control register layout
    typedef struct packed {
        logic flowthrough_direction;
        logic flowthrough_select;
        logic acknowledge_enable_n;
        logic expansion_request_enable;
        logic [11:0] other;
    } dhg_exp_ctl_t;

    // one controller access request
    typedef struct packed {
        logic write;
        logic ptr_sel;
        logic iack;
        logic slow;
        logic [15:0] wdata;
    } dhg_acc_req_t;

    // controller pin drive
    typedef struct packed {
        logic cs_b;
        logic rd_b;
        logic wr_b;
        logic ptr_sel;
        logic interrupt_grant_pulse;
        logic data_oe;
        logic [15:0] data;
    } dhg_pin_t;

endpackage : dhg_pkg

// ==== rtl/dhg_cfg_regs.sv ====
// Purpose: software-written configuration bits of the dma glue
// Assumes: write strobes are single-cycle and already decoded
// Notes: the low status byte of the system register is never stored
`timescale 1ns/1ps
`include "dhg_consts.svh"
module dhg_cfg_regs
    import dhg_pkg::*;
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    // write port
    input wire logic i_wr_sys,
    input wire logic i_wr_exp,
    input wire logic [15:0] i_wdata,
    // register contents
    output dhg_sys_cfg_t o_sys,
    output dhg_exp_ctl_t o_exp
);

    typedef struct packed {
        dhg_sys_cfg_t sys;
        dhg_exp_ctl_t exp;
    } dhg_cfg_state_t;

    dhg_cfg_state_t st;
    dhg_cfg_state_t next_st;

    // ==========
    // write decode; the read-only low byte is dropped on write
    always_comb
    begin
        next_st = st;
        if (i_wr_sys)
        begin
            next_st.sys = dhg_sys_cfg_t'({i_wdata[15:`DHG_SYS_RO_MSB + 1], 8'h00});
        end
        if (i_wr_exp)
        begin
            next_st.exp = dhg_exp_ctl_t'(i_wdata);
        end
    end

    // state register; controls come up inactive except acknowledge, which acknowledge_enable_n at 0 leaves enabled
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            st.sys <= dhg_sys_cfg_t'(`DHG_SYS_CFG_RST);
            st.exp <= dhg_exp_ctl_t'(`DHG_EXP_CTL_RST);
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_sys = st.sys;
    assign o_exp = st.exp;

endmodule : dhg_cfg_regs

// ==== rtl/dhg_access_seq.sv ====
// Purpose: timed access cycles to the external dma controller
// Assumes: i_rd_sync is the controller data bus after two flip-flops
// Notes: strobe must last at least three cycles so synced read data is settled
`timescale 1ns/1ps
`include "dhg_consts.svh"
module dhg_access_seq
    import dhg_pkg::*;
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    // request
    input wire logic i_start,
    input wire dhg_acc_req_t i_req,
    input wire logic [15:0] i_rd_sync,
    // answer
    output logic o_busy,
    output logic o_done,
    output logic [15:0] o_rdata,
    // controller pins
    output dhg_pin_t o_pin
);

    typedef struct packed {
        dhg_seq_state_t state;
        logic [5:0] cnt;
        dhg_acc_req_t req;
        dhg_pin_t pin;
        logic done;
        logic [15:0] rdata;
    } dhg_seq_t;

    dhg_seq_t st;
    dhg_seq_t next_st;

    // strobe length, stretched for slow register reads
    function automatic logic [5:0] strobe_len(input dhg_acc_req_t r);
        if (r.iack)
            strobe_len = 6'(`DHG_IACK_CYC);
        else if (r.slow && !r.write)
            strobe_len = 6'(`DHG_STROBE_CYC + `DHG_SLOW_EXTRA_CYC);
        else
            strobe_len = 6'(`DHG_STROBE_CYC);
    endfunction : strobe_len

    // ==========
    // sequencer: setup, strobe, recover
    always_comb
    begin
        next_st = st;
        next_st.done = 1'b0;
        case (st.state)
            SEQ_IDLE:
            begin
                if (i_start)
                begin
                    next_st.req = i_req;
                    next_st.cnt = 6'(`DHG_SETUP_CYC - 1);
                    next_st.state = SEQ_SETUP;
                    next_st.pin.ptr_sel = i_req.ptr_sel;
                    next_st.pin.cs_b = i_req.iack;
                    next_st.pin.data = i_req.wdata;
                    next_st.pin.data_oe = i_req.write && !i_req.iack;
                end
            end
            SEQ_SETUP:
            begin
                if (st.cnt == 6'h00)
                begin
                    next_st.state = SEQ_STROBE;
                    next_st.cnt = strobe_len(st.req) - 6'h01;
                    next_st.pin.interrupt_grant_pulse = st.req.iack;
                    next_st.pin.rd_b = st.req.iack || st.req.write;
                    next_st.pin.wr_b = st.req.iack || !st.req.write;
                end
                else
                begin
                    next_st.cnt = st.cnt - 6'h01;
                end
            end
            SEQ_STROBE:
            begin
                if (st.cnt == 6'h00)
                begin
                    next_st.state = SEQ_RECOVER;
                    next_st.cnt = 6'(`DHG_RECOVER_CYC - 1);
                    next_st.pin.interrupt_grant_pulse = 1'b0;
                    next_st.pin.rd_b = 1'b1;
                    next_st.pin.wr_b = 1'b1;
                    next_st.rdata = st.req.write ? 16'h0000 : i_rd_sync;
                end
                else
                begin
                    next_st.cnt = st.cnt - 6'h01;
                end
            end
            SEQ_RECOVER:
            begin
                next_st.pin.data_oe = 1'b0;
                next_st.pin.cs_b = 1'b1;
                if (st.cnt == 6'h00)
                begin
                    next_st.state = SEQ_IDLE;
                    next_st.done = 1'b1;
                    next_st.pin.ptr_sel = 1'b0;
                end
                else
                begin
                    next_st.cnt = st.cnt - 6'h01;
                end
            end
            default:
            begin
                next_st.state = SEQ_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            st.state <= SEQ_IDLE;
            st.cnt <= 6'h00;
            st.req <= '0;
            st.pin <= '{cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1, default: '0};
            st.done <= 1'b0;
            st.rdata <= 16'h0000;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_busy = (st.state != SEQ_IDLE);
    assign o_done = st.done;
    assign o_rdata = st.rdata;
    assign o_pin = st.pin;

endmodule : dhg_access_seq

// ==== rtl/dhg_top.sv ====
// Purpose: glue between the host local i/o port and an external two-channel dma controller
// Assumes: host issues one request at a time, I_REQ held one cycle while O_BUSY is low
// Notes: controller pins and expansion-bus signals are asynchronous and are synchronised here
`timescale 1ns/1ps
`include "dhg_consts.svh"

// Contract
// - Any pointer port access drives pointer/data select high.
// - A pointer port write loads the controller's pointer register.
// - Data port accesses reach the pointed-to register with pointer/data select low.
// - An acknowledge-address write gives one pulse on the grant input.
// - The software-terminate bit asserts end-of-process.
// - The transfer-complete enable bit forwards transfer-complete to the expansion bus.
// - The slow-read bit adds wait states to every controller read.
// - The flow-through direction bit sets channel 2's direction in flow-through mode.
// - The flow-through select bit picks flow-through or fly-by mode for channel 2.
// - Acknowledge-enable-low at 0 lets channel 2 acknowledge in fly-by, at 1 holds it off.
// - Request-enable at 1 passes expansion-bus requests, at 0 blocks them.
// - Terminate, done-enable and slow-read bits live in the system configuration register.
module dhg_top
    import dhg_pkg::*;
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    // host local i/o port
    input wire logic I_REQ,
    input wire logic I_WE,
    input wire logic [31:0] I_ADDR,
    input wire logic [15:0] I_WDATA,
    output logic O_BUSY,
    output logic O_ACK,
    output logic [15:0] O_RDATA,
    // system status inputs for the read-only low byte
    input wire logic [7:0] I_SYS_STATUS,
    // dma controller bus
    output logic O_DMAC_CS_B,
    output logic O_DMAC_RD_B,
    output logic O_DMAC_WR_B,
    output logic O_DMAC_PTR_SEL,
    output logic O_DMAC_INTERRUPT_GRANT_PULSE,
    input wire logic [15:0] I_DMAC_DATA,
    output logic [15:0] O_DMAC_DATA,
    output logic O_DMAC_DATA_OE,
    // dma controller channel signals
    output logic O_DMAC_END_OF_PROCESS,
    input wire logic I_DMAC_TRANSFER_COMPLETE,
    output logic O_DMAC_EXP_REQ,
    input wire logic I_DMAC_EXP_ACK,
    output logic O_DMAC_FLOWTHROUGH_SELECT,
    output logic O_DMAC_FLOWTHROUGH_DIRECTION,
    // expansion bus
    input wire logic I_EXP_REQ,
    output logic O_EXP_ACK,
    output logic O_EXP_TRANSFER_COMPLETE
);

    // ==========
    // state
    typedef struct packed {
        logic [15:0] data_s1;
        logic [15:0] data_s2;
        logic [7:0] status_s1;
        logic [7:0] status_s2;
        logic tc_s1;
        logic tc_s2;
        logic dreq_s1;
        logic dreq_s2;
        logic dack_s1;
        logic dack_s2;
        logic wait_seq;
        logic ack;
        logic [15:0] rdata;
        logic exp_tc;
        logic dmac_req;
        logic exp_ack;
        logic eop;
    } dhg_top_state_t;

    dhg_top_state_t st;
    dhg_top_state_t next_st;

    dhg_sys_cfg_t sys_cfg;
    dhg_exp_ctl_t exp_ctl;
    dhg_acc_req_t acc_req;
    dhg_pin_t pin;
    logic seq_busy;
    logic seq_done;
    logic [15:0] seq_rdata;
    logic take;
    logic hit_data;
    logic hit_ptr;
    logic hit_iack;
    logic hit_sys;
    logic hit_exp;
    logic seq_start;
    logic wr_sys;
    logic wr_exp;

    // address compare used by every decode line
    function automatic logic addr_is(input logic [31:0] a, input logic [31:0] target);
        addr_is = (a == target);
    endfunction : addr_is

    // ==========
    // host request decode
    assign take = I_REQ && !O_BUSY;
    assign hit_data = addr_is(I_ADDR, `DHG_ADDR_DATA);
    assign hit_ptr = addr_is(I_ADDR, `DHG_ADDR_PTR);
    assign hit_iack = addr_is(I_ADDR, `DHG_ADDR_IACK);
    assign hit_sys = addr_is(I_ADDR, `DHG_ADDR_SYS_CFG);
    assign hit_exp = addr_is(I_ADDR, `DHG_ADDR_EXP_CTL);

    // a read of the acknowledge address only answers; a write pulses the grant
    assign seq_start = take && (hit_data || hit_ptr || (hit_iack && I_WE));
    assign wr_sys = take && I_WE && hit_sys;
    assign wr_exp = take && I_WE && hit_exp;

    // request carried to the sequencer
    always_comb
    begin
        acc_req.write = I_WE;
        acc_req.ptr_sel = hit_ptr;
        acc_req.iack = hit_iack;
        acc_req.slow = sys_cfg.slow_register_read_enable;
        acc_req.wdata = I_WDATA;
    end

    // ==========
    // configuration registers
    dhg_cfg_regs u_cfg (
        .I_CLK(I_CLK),
        .I_RST_B(I_RST_B),
        .i_wr_sys(wr_sys),
        .i_wr_exp(wr_exp),
        .i_wdata(I_WDATA),
        .o_sys(sys_cfg),
        .o_exp(exp_ctl)
    );

    // controller access sequencer
    dhg_access_seq u_seq (
        .I_CLK(I_CLK),
        .I_RST_B(I_RST_B),
        .i_start(seq_start),
        .i_req(acc_req),
        .i_rd_sync(st.data_s2),
        .o_busy(seq_busy),
        .o_done(seq_done),
        .o_rdata(seq_rdata),
        .o_pin(pin)
    );

    // ==========
    // next state: synchronisers, host answer, channel signal gating
    always_comb
    begin
        next_st = st;
        // two-stage synchronisers; stage one feeds only stage two
        next_st.data_s1 = I_DMAC_DATA;
        next_st.data_s2 = st.data_s1;
        next_st.status_s1 = I_SYS_STATUS;
        next_st.status_s2 = st.status_s1;
        next_st.tc_s1 = I_DMAC_TRANSFER_COMPLETE;
        next_st.tc_s2 = st.tc_s1;
        next_st.dreq_s1 = I_EXP_REQ;
        next_st.dreq_s2 = st.dreq_s1;
        next_st.dack_s1 = I_DMAC_EXP_ACK;
        next_st.dack_s2 = st.dack_s1;

        // host answer: local registers in one cycle, controller when the sequencer ends
        next_st.ack = 1'b0;
        if (seq_start)
        begin
            next_st.wait_seq = 1'b1;
        end
        else if (take)
        begin
            next_st.ack = 1'b1;
            if (I_WE)
            begin
                next_st.rdata = 16'h0000;
            end
            else if (hit_sys)
            begin
                next_st.rdata = {sys_cfg[15:`DHG_SYS_RO_MSB + 1], st.status_s2};
            end
            else if (hit_exp)
            begin
                next_st.rdata = exp_ctl;
            end
            else
            begin
                next_st.rdata = 16'h0000; // unmapped or acknowledge-address read
            end
        end
        if (st.wait_seq && seq_done)
        begin
            next_st.wait_seq = 1'b0;
            next_st.ack = 1'b1;
            next_st.rdata = seq_rdata;
        end

        // channel control
        next_st.eop = sys_cfg.software_terminate;
        next_st.exp_tc = st.tc_s2 && sys_cfg.expansion_done_enable;
        next_st.dmac_req = st.dreq_s2 && exp_ctl.expansion_request_enable;
        // acknowledge only in fly-by and only when enabled
        next_st.exp_ack = st.dack_s2 && !exp_ctl.acknowledge_enable_n && !exp_ctl.flowthrough_select;
    end

    // ==========
    // state register
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ==========
    // host outputs
    assign O_BUSY = seq_busy || st.wait_seq;
    assign O_ACK = st.ack;
    assign O_RDATA = st.rdata;

    // controller bus pins
    assign O_DMAC_CS_B = pin.cs_b;
    assign O_DMAC_RD_B = pin.rd_b;
    assign O_DMAC_WR_B = pin.wr_b;
    assign O_DMAC_PTR_SEL = pin.ptr_sel;
    assign O_DMAC_INTERRUPT_GRANT_PULSE = pin.interrupt_grant_pulse;
    assign O_DMAC_DATA = pin.data;
    assign O_DMAC_DATA_OE = pin.data_oe;

    // channel signals
    assign O_DMAC_END_OF_PROCESS = st.eop;
    assign O_EXP_TRANSFER_COMPLETE = st.exp_tc;
    assign O_DMAC_EXP_REQ = st.dmac_req;
    assign O_EXP_ACK = st.exp_ack;
    assign O_DMAC_FLOWTHROUGH_SELECT = exp_ctl.flowthrough_select;
    assign O_DMAC_FLOWTHROUGH_DIRECTION = exp_ctl.flowthrough_direction;

endmodule : dhg_top

// ==== sim/dhg_top_assertions.sv ====
// Purpose: port assertions for dhg_top
// Assumes: one clock, async active-low reset
// Notes: shadows follow config writes seen at the host port
`timescale 1ns/1ps
`include "dhg_consts.svh"
module dhg_top_chk
(
    // clock, reset and host port
    input wire logic I_CLK, I_RST_B, I_REQ, I_WE, O_BUSY, O_ACK,
    input wire logic [31:0] I_ADDR,
    input wire logic [15:0] I_WDATA, O_DMAC_DATA,
    // controller and expansion bus
    input wire logic O_DMAC_CS_B, O_DMAC_RD_B, O_DMAC_WR_B, O_DMAC_PTR_SEL, O_DMAC_DATA_OE,
    input wire logic O_DMAC_INTERRUPT_GRANT_PULSE, O_DMAC_END_OF_PROCESS, I_DMAC_TRANSFER_COMPLETE,
    input wire logic O_DMAC_EXP_REQ, I_DMAC_EXP_ACK, O_EXP_ACK, O_EXP_TRANSFER_COMPLETE, I_EXP_REQ,
    input wire logic O_DMAC_FLOWTHROUGH_SELECT, O_DMAC_FLOWTHROUGH_DIRECTION
);
    // ==========
    // helper logic
    logic take, ctl, ptr_sh;
    logic [15:0] sys_sh, exp_sh, wd_sh;
    logic [5:0] cnt, lat;
    assign take = I_REQ && !O_BUSY;
    assign ctl = I_ADDR == `DHG_ADDR_DATA || I_ADDR == `DHG_ADDR_PTR;
    // shadows and answer latency, latched when a request is taken
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            sys_sh <= 16'h0000;
            exp_sh <= 16'h0000;
            wd_sh <= 16'h0000;
            ptr_sh <= 1'b0;
            lat <= 6'h00;
            cnt <= 6'h00;
        end
        else
        begin
            cnt <= take ? 6'h00 : cnt + 6'h01;
            if (take)
            begin
                wd_sh <= I_WDATA;
                lat <= !ctl ? ((I_WE && I_ADDR == `DHG_ADDR_IACK) ? 6'h0A : 6'h00)
                    : ((!I_WE && sys_sh[13]) ? 6'h1F : 6'h0B);
            end
            if (take && ctl)
                ptr_sh <= I_ADDR == `DHG_ADDR_PTR;
            if (take && I_WE && I_ADDR == `DHG_ADDR_SYS_CFG)
                sys_sh <= I_WDATA;
            if (take && I_WE && I_ADDR == `DHG_ADDR_EXP_CTL)
                exp_sh <= I_WDATA;
        end
    end
    // ==========
    // assertions
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    property p_psel; !O_DMAC_CS_B |-> O_DMAC_PTR_SEL == ptr_sh; endproperty
    a_psel: assert property (p_psel) else $error("pointer select wrong");
    property p_wdat; !O_DMAC_WR_B |-> O_DMAC_DATA_OE && O_DMAC_DATA == wd_sh; endproperty
    a_wdat: assert property (p_wdat) else $error("write data wrong");
    property p_rstb; $fell(O_DMAC_RD_B) |-> !O_DMAC_CS_B && $past(!O_DMAC_CS_B); endproperty
    a_rstb: assert property (p_rstb) else $error("read strobe outside select");
    property p_gw; $rose(O_DMAC_INTERRUPT_GRANT_PULSE) |-> O_DMAC_INTERRUPT_GRANT_PULSE[*5] ##1 !O_DMAC_INTERRUPT_GRANT_PULSE;
    endproperty
    a_gw: assert property (p_gw) else $error("grant pulse width");
    property p_gc; take && I_WE && I_ADDR == `DHG_ADDR_IACK |-> ##[1:3] $rose(O_DMAC_INTERRUPT_GRANT_PULSE); endproperty
    a_gc: assert property (p_gc) else $error("no grant pulse");
    property p_lat; O_ACK |-> cnt == lat; endproperty
    a_lat: assert property (p_lat) else $error("answer latency wrong");
    property p_eop; $stable(sys_sh[10])[*3] |-> O_DMAC_END_OF_PROCESS == sys_sh[10]; endproperty
    a_eop: assert property (p_eop) else $error("end of process wrong");
    property p_tc; ($stable(I_DMAC_TRANSFER_COMPLETE) && $stable(sys_sh[12]))[*6]
        |-> O_EXP_TRANSFER_COMPLETE == (I_DMAC_TRANSFER_COMPLETE && sys_sh[12]); endproperty
    a_tc: assert property (p_tc) else $error("transfer complete wrong");
    property p_req; ($stable(I_EXP_REQ) && $stable(exp_sh[12]))[*6]
        |-> O_DMAC_EXP_REQ == (I_EXP_REQ && exp_sh[12]); endproperty
    a_req: assert property (p_req) else $error("request gating wrong");
    property p_ack; ($stable(I_DMAC_EXP_ACK) && $stable(exp_sh[14:13]))[*6]
        |-> O_EXP_ACK == (I_DMAC_EXP_ACK && exp_sh[14:13] == 2'h0); endproperty
    a_ack: assert property (p_ack) else $error("acknowledge gating wrong");
    property p_flow; $stable(exp_sh[15:14])[*3]
        |-> {O_DMAC_FLOWTHROUGH_DIRECTION, O_DMAC_FLOWTHROUGH_SELECT} == exp_sh[15:14]; endproperty
    a_flow: assert property (p_flow) else $error("flow-through controls wrong");
    property p_rst; $rose(I_RST_B) |-> O_DMAC_CS_B && !O_DMAC_END_OF_PROCESS && !O_EXP_TRANSFER_COMPLETE && !O_BUSY;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs active after reset");
    // main scenarios
    c_slow: cover property (O_ACK && lat == 6'h1F);
    c_grant: cover property ($rose(O_DMAC_INTERRUPT_GRANT_PULSE));
    c_eop: cover property ($rose(O_DMAC_END_OF_PROCESS));
endmodule : dhg_top_chk

bind dhg_top dhg_top_chk u_chk (.*);

// ==== sim/dhg_dmac_model.sv ====
// Purpose: behavioural two-channel dma controller on the glue's far side
// Assumes: pointer selects one of sixteen internal registers
// Notes: released data bus shows the inverse of its last value
`timescale 1ns/1ps
module dhg_dmac_model
(
    // controller bus
    input wire logic i_clk, i_cs_b, i_rd_b, i_wr_b, i_ptr_sel, i_grant,
    input wire logic [15:0] i_data,
    output logic [15:0] o_data,
    // grant pulses seen
    output logic [7:0] o_grant_cnt
);
    logic [15:0] regs [16];
    logic [15:0] last = 16'h0000;
    logic [3:0] ptr = 4'h0;
    logic grant_q = 1'b0;
    logic [7:0] grants = 8'h00;
    assign o_grant_cnt = grants;
    // register writes and grant counting
    always @(posedge i_clk)
    begin
        if (!i_cs_b && !i_wr_b && i_ptr_sel)
            ptr <= i_data[3:0];
        if (!i_cs_b && !i_wr_b && !i_ptr_sel)
            regs[ptr] <= i_data;
        if (i_grant && !grant_q)
            grants <= grants + 8'h01;
        grant_q <= i_grant;
        if (!i_cs_b && !i_rd_b)
            last <= o_data;
    end
    // read drive: pointer or pointed register, else a changed value
    assign o_data = (!i_cs_b && !i_rd_b) ? (i_ptr_sel ? {12'h000, ptr} : regs[ptr]) : ~last;
endmodule : dhg_dmac_model

// ==== sim/dhg_top_tb_top.sv ====
// Purpose: self-checking bench for dhg_top
// Assumes: one host request at a time, controller model on the far side
// Notes: expectations come from the register layout and access timing
`timescale 1ns/1ps
`include "dhg_consts.svh"
module dhg_top_tb_top;
    // ==========
    // signals
    logic clk, rst_b, req, we, cs_b, rd_b, wr_b, psel, grant, oe, eop, tc, xreq, xack;
    logic busy, ack, xreq_o, xack_o, xtc, fsel, fdir;
    logic [31:0] addr;
    logic [15:0] wdata, rdata, dout, mq, dq, rq;
    logic [7:0] status, gcnt, g0;
    logic [3:0] k;
    int rn, n0, fail_count, compares;
    assign dq = oe ? dout : mq;
    dhg_top dut (.I_CLK(clk), .I_RST_B(rst_b), .I_REQ(req), .I_WE(we), .I_ADDR(addr), .I_WDATA(wdata),
        .O_BUSY(busy), .O_ACK(ack), .O_RDATA(rdata), .I_SYS_STATUS(status), .O_DMAC_CS_B(cs_b),
        .O_DMAC_RD_B(rd_b), .O_DMAC_WR_B(wr_b), .O_DMAC_PTR_SEL(psel), .O_DMAC_INTERRUPT_GRANT_PULSE(grant),
        .I_DMAC_DATA(dq), .O_DMAC_DATA(dout), .O_DMAC_DATA_OE(oe), .O_DMAC_END_OF_PROCESS(eop),
        .I_DMAC_TRANSFER_COMPLETE(tc), .O_DMAC_EXP_REQ(xreq_o), .I_DMAC_EXP_ACK(xack), .O_EXP_ACK(xack_o),
        .O_DMAC_FLOWTHROUGH_SELECT(fsel), .O_DMAC_FLOWTHROUGH_DIRECTION(fdir), .I_EXP_REQ(xreq),
        .O_EXP_TRANSFER_COMPLETE(xtc));
    dhg_dmac_model mdl (.i_clk(clk), .i_cs_b(cs_b), .i_rd_b(rd_b), .i_wr_b(wr_b), .i_ptr_sel(psel),
        .i_grant(grant), .i_data(dq), .o_data(mq), .o_grant_cnt(gcnt));
    // clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ==========
    // tasks
    task automatic stop_test();
        $display("counts compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk
    // one host access: a one-cycle request, then a bounded wait for the answer
    task automatic host(input logic w, input logic [31:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        rn = 0;
        while (ack !== 1'b1 && rn < 200)
        begin
            @(posedge clk);
            rn++;
        end
        rq = rdata;
        if (rn >= 200)
        begin
            chk(16'h0000, 16'h0001);
            stop_test();
        end
    endtask : host
    // ==========
    // tests
    initial
    begin
        rst_b = 1'b0;
        {req, we, tc, xreq, xack} = 5'h00;
        addr = 32'h0000_0000;
        wdata = 16'h0000;
        status = 8'h5A;
        fail_count = 0;
        compares = 0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        host(1'b0, `DHG_ADDR_SYS_CFG, 16'h0000);
        chk(rq, 16'h005A);
        host(1'b0, `DHG_ADDR_EXP_CTL, 16'h0000);
        chk(rq, 16'h0000);
        chk(16'({xtc, eop}), 16'h0000);
        $display("test reset done");
        host(1'b1, `DHG_ADDR_PTR, 16'h0003);
        host(1'b0, `DHG_ADDR_PTR, 16'h0000);
        chk(rq, 16'h0003);
        for (int i = 0; i < 4; i++)
        begin
            host(1'b1, `DHG_ADDR_PTR, 16'(i));
            host(1'b1, `DHG_ADDR_DATA, 16'hA5C0 + 16'(i));
        end
        for (int i = 3; i >= 0; i--)
        begin
            host(1'b1, `DHG_ADDR_PTR, 16'(i));
            host(1'b0, `DHG_ADDR_DATA, 16'h0000);
            chk(rq, 16'hA5C0 + 16'(i));
        end
        $display("test pointer and data done");
        g0 = gcnt;
        host(1'b1, `DHG_ADDR_IACK, 16'h0000);
        chk({8'h00, gcnt}, {8'h00, g0 + 8'h01});
        host(1'b0, `DHG_ADDR_IACK, 16'h0000);
        chk({gcnt, rq[7:0]}, {g0 + 8'h01, 8'h00});
        $display("test grant done");
        host(1'b1, `DHG_ADDR_PTR, 16'h0001);
        host(1'b0, `DHG_ADDR_DATA, 16'h0000);
        n0 = rn;
        host(1'b1, `DHG_ADDR_SYS_CFG, 16'h20FF);
        host(1'b0, `DHG_ADDR_DATA, 16'h0000);
        chk(rq, 16'hA5C1);
        chk(16'(rn - n0), 16'(`DHG_SLOW_EXTRA_CYC));
        host(1'b0, `DHG_ADDR_SYS_CFG, 16'h0000);
        chk(rq, 16'h205A);
        $display("test slow read done");
        tc <= 1'b1;
        host(1'b1, `DHG_ADDR_SYS_CFG, 16'h0400);
        repeat (4) @(posedge clk);
        chk(16'({xtc, eop}), 16'h0001);
        host(1'b1, `DHG_ADDR_SYS_CFG, 16'h1000);
        repeat (4) @(posedge clk);
        chk(16'({xtc, eop}), 16'h0002);
        tc <= 1'b0;
        repeat (5) @(posedge clk);
        chk(16'({xtc, eop}), 16'h0000);
        $display("test terminate and complete done");
        xreq <= 1'b1;
        xack <= 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            k = 4'(i);
            host(1'b1, `DHG_ADDR_EXP_CTL, {k, 12'h000});
            repeat (5) @(posedge clk);
            chk(16'({fdir, fsel, xack_o, xreq_o}), 16'({k[3], k[2], ~k[1] & ~k[2], k[0]}));
            host(1'b0, `DHG_ADDR_EXP_CTL, 16'h0000);
            chk(rq, {k, 12'h000});
        end
        // back to fly-by with requests on while channel 2 is idle
        host(1'b1, `DHG_ADDR_EXP_CTL, 16'h1000);
        {xreq, xack} <= 2'h0;
        repeat (5) @(posedge clk);
        chk(16'({xack_o, xreq_o}), 16'h0000);
        host(1'b0, 32'h1800_0100, 16'h0000);
        $display("test expansion control done");
        stop_test();
    end
endmodule : dhg_top_tb_top
